// ---- design/beat_buffer.sv ----
// Two-entry buffer with valid and ready on both sides.
// Assumes push and pop share clk_in.
`timescale 1ns/1ps
module beat_buffer
#(
   parameter int W = 9
)
(
   input  wire logic         clk_in,
   input  wire logic         rst_n_in,
   input  wire logic         in_valid_in,
   input  wire logic [W-1:0] in_data_in,
   output logic              in_ready_out,
   output logic              out_valid_out,
   output logic      [W-1:0] out_data_out,
   input  wire logic         out_ready_in
);

   logic [W-1:0] slot [2];
   logic [W-1:0] next_slot [2];
   logic [1:0]   count;
   logic [1:0]   next_count;
   logic         push;
   logic         pop;

   assign in_ready_out  = (count != 2'h2);
   assign out_valid_out = (count != 2'h0);
   assign out_data_out  = slot[0];
   assign push          = in_valid_in && in_ready_out;
   assign pop           = out_valid_out && out_ready_in;

   // Slot 0 is always the head; a pop shifts slot 1 down
   always_comb
   begin
      next_slot[0] = slot[0];
      next_slot[1] = slot[1];
      next_count   = count;
      if (pop)
      begin
         next_slot[0] = slot[1];
      end
      if (push)
      begin
         if (count == 2'h0 || (count == 2'h1 && pop))
            next_slot[0] = in_data_in;
         else
            next_slot[1] = in_data_in;
      end
      next_count = 2'(count + {1'b0, push} - {1'b0, pop});
   end

   // Storage registers
   always_ff @(posedge clk_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
      begin
         slot[0] <= '0;
         slot[1] <= '0;
         count   <= 2'h0;
      end
      else
      begin
         slot[0] <= next_slot[0];
         slot[1] <= next_slot[1];
         count   <= next_count;
      end
   end

endmodule

// ---- design/ddr2_command_strobe_pins.sv ----
// DDR2 pin-level command decode, clock gating, write masking and strobes.
// Assumes all pin inputs are asynchronous to clk_in; the link clock is
// sampled, so it must be far slower than clk_in (125 ns against 5 ns).
// How it works
// - Complement strobe used only if disable bit zero
// - Chip select high masks the whole command
// - Row, column, write strobes form command code
// - Masked write beats stored with keep flag clear
// - Mask sampled on both strobe edges
// - Read strobe enabled by extended register bit
// - Shared pin drives only with read data
// - Read strobe on disables write masking
// - Complement read strobe needs both modes on
// - Command inputs registered on link clock rising crossing
// - Read beats on both link clock crossings
// - Clock enable starts and stops internal clocking
// - Strobe driven by device only for reads
// - Read strobe edges aligned with data edges
`timescale 1ns/1ps
`include "ddr2_pin_map.svh"
module ddr2_command_strobe_pins
   import ddr2_pin_pkg::*;
(
   input  wire logic                clk_in,
   input  wire logic                rst_n_in,
   // Pins to and from the controller
   input  wire logic                link_clk_in,
   input  wire logic                cke_in,
   input  wire logic                cs_n_in,
   input  wire logic                ras_n_in,
   input  wire logic                cas_n_in,
   input  wire logic                we_n_in,
   input  wire logic [`BANK_W-1:0]  bank_in,
   input  wire logic [`ADDR_W-1:0]  addr_in,
   input  wire logic [`DQ_W-1:0]    dq_in,
   output logic      [`DQ_W-1:0]    dq_out,
   output logic                     dq_oe_out,
   input  wire logic                dqs_in,
   output logic                     dqs_out,
   output logic                     dqs_oe_out,
   output logic                     dqs_n_out,
   output logic                     dqs_n_oe_out,
   input  wire logic                write_data_mask_in,
   output logic                     read_data_strobe_out,
   output logic                     read_data_strobe_oe_out,
   output logic                     read_data_strobe_n_out,
   output logic                     read_data_strobe_n_oe_out,
   // Array side: decoded commands
   output logic                     cmd_valid_out,
   output cmd_e                     cmd_code_out,
   output logic      [`BANK_W-1:0]  cmd_bank_out,
   output logic      [`ADDR_W-1:0]  cmd_addr_out,
   output logic                     clock_run_out,
   output logic                     strobe_diff_out,
   output logic                     read_strobe_en_out,
   // Array side: write beats
   output logic                     wr_valid_out,
   output logic      [`DQ_W-1:0]    wr_data_out,
   output logic                     wr_keep_out,
   input  wire logic                wr_ready_in,
   output logic                     wr_overrun_out,
   // Array side: read beats
   input  wire logic                rd_valid_in,
   input  wire logic [`DQ_W-1:0]    rd_data_in,
   output logic                     rd_ready_out
);

   // ---------------------------------------------------------------
   // Pin sampling
   // ---------------------------------------------------------------
   logic [`PIN_BUNDLE_W-1:0] pins_s;
   logic                     ck_s;
   logic                     cke_s;
   logic                     cs_n_s;
   logic [2:0]               cmd_s;
   logic [`BANK_W-1:0]       bank_s;
   logic [`ADDR_W-1:0]       addr_s;
   logic                     dqs_s;
   logic                     mask_s;
   logic [`DQ_W-1:0]         dq_s;

   // All pins share one synchroniser so the bundle keeps its alignment
   pin_sync #(.W(`PIN_BUNDLE_W)) u_sync
   (
      .clk_in   (clk_in),
      .rst_n_in (rst_n_in),
      .async_in ({link_clk_in, cke_in, cs_n_in, ras_n_in, cas_n_in, we_n_in,
                  bank_in, addr_in, dqs_in, write_data_mask_in, dq_in}),
      .sync_out (pins_s)
   );

   assign {ck_s, cke_s, cs_n_s, cmd_s, bank_s, addr_s, dqs_s, mask_s, dq_s} = pins_s;

   // ---------------------------------------------------------------
   // Edge detection
   // ---------------------------------------------------------------
   logic ck_d;
   logic dqs_d;
   logic ck_rise;
   logic ck_cross;
   logic dqs_edge;

   always_ff @(posedge clk_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
      begin
         ck_d  <= 1'b0;
         dqs_d <= 1'b0;
      end
      else
      begin
         ck_d  <= ck_s;
         dqs_d <= dqs_s;
      end
   end

   assign ck_rise  = ck_s && !ck_d;
   assign ck_cross = ck_s != ck_d;
   assign dqs_edge = dqs_s != dqs_d;

   // ---------------------------------------------------------------
   // Command capture, clock enable and extended mode register one
   // ---------------------------------------------------------------
   logic               next_clock_run;
   logic               next_cmd_valid;
   cmd_e               next_cmd_code;
   logic [`BANK_W-1:0] next_cmd_bank;
   logic [`ADDR_W-1:0] next_cmd_addr;
   logic               next_strobe_diff;
   logic               next_read_strobe_en;
   logic               cmd_take;

   // Taken on a rising crossing with clocking on and rank selected
   assign cmd_take = ck_rise && clock_run_out && !cs_n_s;

   always_comb
   begin
      next_clock_run      = clock_run_out;
      next_cmd_valid      = 1'b0;
      next_cmd_code       = cmd_code_out;
      next_cmd_bank       = cmd_bank_out;
      next_cmd_addr       = cmd_addr_out;
      next_strobe_diff    = strobe_diff_out;
      next_read_strobe_en = read_strobe_en_out;
      if (ck_rise)
         next_clock_run = cke_s;
      if (cmd_take)
      begin
         next_cmd_valid = 1'b1;
         next_cmd_code  = cmd_e'(cmd_s);
         next_cmd_bank  = bank_s;
         next_cmd_addr  = addr_s;
         if (cmd_e'(cmd_s) == cmd_mode_set && bank_s == `BANK_EXT_ONE)
         begin
            next_strobe_diff    = !addr_s[`EXT_ONE_DIFF_OFF_BIT];
            next_read_strobe_en = addr_s[`EXT_ONE_RD_STB_BIT];
         end
      end
   end

   always_ff @(posedge clk_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
      begin
         clock_run_out      <= 1'b0;
         cmd_valid_out      <= 1'b0;
         cmd_code_out       <= cmd_nop;
         cmd_bank_out       <= '0;
         cmd_addr_out       <= '0;
         strobe_diff_out    <= `STROBE_DIFF_RST;
         read_strobe_en_out <= `RD_STB_EN_RST;
      end
      else
      begin
         clock_run_out      <= next_clock_run;
         cmd_valid_out      <= next_cmd_valid;
         cmd_code_out       <= next_cmd_code;
         cmd_bank_out       <= next_cmd_bank;
         cmd_addr_out       <= next_cmd_addr;
         strobe_diff_out    <= next_strobe_diff;
         read_strobe_en_out <= next_read_strobe_en;
      end
   end

   // ---------------------------------------------------------------
   // Write beat capture
   // ---------------------------------------------------------------
   logic rd_active;
   logic beat_push;
   logic beat_keep;
   logic buf_ready;

   // The strobe belongs to the controller only while no read is driven
   assign beat_push = dqs_edge && !rd_active;
   // With the read strobe on, the shared pin is not a mask at all
   assign beat_keep = read_strobe_en_out || !mask_s;
   // A beat cannot be stalled on the pins; a full buffer is reported
   assign wr_overrun_out = beat_push && !buf_ready;

   beat_buffer #(.W(`DQ_W + 1)) u_wbuf
   (
      .clk_in        (clk_in),
      .rst_n_in      (rst_n_in),
      .in_valid_in   (beat_push),
      .in_data_in    ({beat_keep, dq_s}),
      .in_ready_out  (buf_ready),
      .out_valid_out (wr_valid_out),
      .out_data_out  ({wr_keep_out, wr_data_out}),
      .out_ready_in  (wr_ready_in)
   );

   // ---------------------------------------------------------------
   // Read burst sequencer and strobe drive
   // ---------------------------------------------------------------
   rd_state_e        state;
   rd_state_e        next_state;
   logic [2:0]       beats;
   logic [2:0]       next_beats;
   logic             next_dqs;
   logic [`DQ_W-1:0] next_dq;
   logic             read_cmd;

   assign read_cmd     = cmd_take && cmd_e'(cmd_s) == cmd_read;
   assign rd_active    = state != rd_idle;
   assign rd_ready_out = (state == rd_burst) && ck_cross;

   // Strobe toggles with each beat; it idles low from command to first beat
   always_comb
   begin
      next_state = state;
      next_beats = beats;
      next_dqs   = dqs_out;
      next_dq    = dq_out;
      unique case (state)
         rd_idle:
         begin
            next_dqs = 1'b0;
            if (read_cmd)
            begin
               next_state = rd_burst;
               next_beats = `BEAT_ZERO;
            end
         end
         rd_burst:
         begin
            if (ck_cross)
            begin
               next_dq    = rd_valid_in ? rd_data_in : dq_out;
               next_dqs   = !dqs_out;
               next_beats = 3'(beats + `BEAT_ONE);
               if (next_beats == `BURST_BEATS)
                  next_state = rd_post;
            end
         end
         rd_post:
         begin
            next_dqs = 1'b0;
            if (ck_cross)
               next_state = rd_idle;
         end
      endcase
   end

   always_ff @(posedge clk_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
      begin
         state   <= rd_idle;
         beats   <= `BEAT_ZERO;
         dqs_out <= 1'b0;
         dq_out  <= `DQ_RST;
      end
      else
      begin
         state   <= next_state;
         beats   <= next_beats;
         dqs_out <= next_dqs;
         dq_out  <= next_dq;
      end
   end

   // Pin drivers: complements and the shared pin follow the true strobe
   assign dq_oe_out                 = rd_active;
   assign dqs_oe_out                = rd_active;
   assign dqs_n_out                 = !dqs_out;
   assign dqs_n_oe_out              = rd_active && strobe_diff_out;
   assign read_data_strobe_out      = dqs_out;
   assign read_data_strobe_oe_out   = rd_active && read_strobe_en_out;
   assign read_data_strobe_n_out    = !dqs_out;
   assign read_data_strobe_n_oe_out = rd_active && read_strobe_en_out
                                      && strobe_diff_out;

   // ---------------------------------------------------------------
   // Assertions
   // ---------------------------------------------------------------
   a_cs_masks_cmd: assert property (@(posedge clk_in) disable iff (!rst_n_in)
      (ck_rise && cs_n_s) |=> !cmd_valid_out)
      else $error("command taken while chip select high");
   a_cmd_code_taken: assert property (@(posedge clk_in) disable iff (!rst_n_in)
      (ck_rise && !cs_n_s && clock_run_out) |=>
         (cmd_valid_out && cmd_code_out == cmd_e'($past(cmd_s))))
      else $error("command code not decoded from strobes");
   a_cke_gates_cmd: assert property (@(posedge clk_in) disable iff (!rst_n_in)
      (ck_rise && !cke_s) |=> (!clock_run_out ##1 !cmd_valid_out))
      else $error("clock enable low did not stop command intake");
   a_cmd_on_rise: assert property (@(posedge clk_in) disable iff (!rst_n_in)
      cmd_valid_out |-> $past(ck_rise))
      else $error("command registered off the rising crossing");
   a_ext_one_strobe: assert property (@(posedge clk_in) disable iff (!rst_n_in)
      (cmd_take && cmd_e'(cmd_s) == cmd_mode_set && bank_s == `BANK_EXT_ONE)
         |=> (strobe_diff_out == !$past(addr_s[`EXT_ONE_DIFF_OFF_BIT])
              && read_strobe_en_out == $past(addr_s[`EXT_ONE_RD_STB_BIT])))
      else $error("extended mode register bits not applied");
   a_mask_keep: assert property (@(posedge clk_in) disable iff (!rst_n_in)
      (beat_push && buf_ready && !wr_valid_out) |=>
         (wr_valid_out && wr_keep_out == !$past(mask_s && !read_strobe_en_out)))
      else $error("write beat keep flag wrong");
   a_strobe_no_mask: assert property (@(posedge clk_in) disable iff (!rst_n_in)
      read_strobe_en_out |-> beat_keep)
      else $error("mask applied while read strobe enabled");
   a_shared_read_only: assert property (@(posedge clk_in) disable iff (!rst_n_in)
      read_data_strobe_oe_out |-> (rd_active && read_strobe_en_out && !beat_push))
      else $error("shared pin driven outside a read");
   a_comp_strobe_gated: assert property (@(posedge clk_in) disable iff (!rst_n_in)
      !strobe_diff_out |-> (!dqs_n_oe_out && !read_data_strobe_n_oe_out))
      else $error("complement strobe driven in single-ended mode");
   a_beat_on_cross: assert property (@(posedge clk_in) disable iff (!rst_n_in)
      (state == rd_burst && $changed(dqs_out)) |-> $past(ck_cross))
      else $error("read beat launched off a clock crossing");
   a_strobe_align: assert property (@(posedge clk_in) disable iff (!rst_n_in)
      ($changed(dq_out)) |-> $changed(dqs_out))
      else $error("read data moved without a strobe edge");
   a_mask_each_edge: assert property (@(posedge clk_in) disable iff (!rst_n_in)
      (!rd_active && dqs_s != dqs_d) |-> beat_push)
      else $error("strobe edge without a beat sample");

endmodule

// ---- design/ddr2_pin_map.svh ----
// Constants for the DDR2 pin-level command and strobe block.
// Assumes inclusion by bare name from design and verification files.
`ifndef DDR2_PIN_MAP_SVH
`define DDR2_PIN_MAP_SVH

// ---------------------------------------------------------------
// Pin widths and sampled bundle layout
// ---------------------------------------------------------------
`define ADDR_W            13
`define BANK_W            2
`define DQ_W              8
`define PIN_BUNDLE_W      31
`define SYNC_STAGES       2

// ---------------------------------------------------------------
// Extended mode register one
// ---------------------------------------------------------------
`define BANK_EXT_ONE         2'h1
`define EXT_ONE_DIFF_OFF_BIT 10
`define EXT_ONE_RD_STB_BIT   11
`define STROBE_DIFF_RST      1'h1
`define RD_STB_EN_RST        1'h0

// ---------------------------------------------------------------
// Read burst
// ---------------------------------------------------------------
`define BURST_BEATS       3'h4
`define BEAT_ZERO         3'h0
`define BEAT_ONE          3'h1
`define DQ_RST            8'h00

`endif

// ---- design/ddr2_pin_pkg.sv ----
// Types for the DDR2 pin-level command and strobe block.
// Assumes nothing beyond a SystemVerilog compiler.
package ddr2_pin_pkg;

   // ---------------------------------------------------------------
   // Command code: {row strobe, column strobe, write enable}, low true
   // ---------------------------------------------------------------
   typedef enum logic [2:0]
   {
      cmd_mode_set  = 3'h0,
      cmd_refresh   = 3'h1,
      cmd_precharge = 3'h2,
      cmd_activate  = 3'h3,
      cmd_write     = 3'h4,
      cmd_read      = 3'h5,
      cmd_terminate = 3'h6,
      cmd_nop       = 3'h7
   } cmd_e;

   // ---------------------------------------------------------------
   // Read burst sequencer, one-hot
   // ---------------------------------------------------------------
   typedef enum logic [2:0]
   {
      rd_idle  = 3'h1,
      rd_burst = 3'h2,
      rd_post  = 3'h4
   } rd_state_e;

endpackage

// ---- design/pin_sync.sv ----
// Two-flop synchroniser for a bundle of pin inputs.
// Assumes the bundle changes slowly against clk_in.
`timescale 1ns/1ps
module pin_sync
#(
   parameter int W = 1
)
(
   input  wire logic         clk_in,
   input  wire logic         rst_n_in,
   input  wire logic [W-1:0] async_in,
   output logic      [W-1:0] sync_out
);

   logic [W-1:0] meta;
   logic [W-1:0] stable;

   // First stage is read only by the second stage
   always_ff @(posedge clk_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
      begin
         meta   <= '0;
         stable <= '0;
      end
      else
      begin
         meta   <= async_in;
         stable <= meta;
      end
   end

   assign sync_out = stable;

endmodule

// ---- verification/ddr2_ctrl_model.sv ----
// Behavioural DDR2 controller: link clock, command pins and write beats.
// Assumes the bench calls its tasks and resolves the shared pins itself.
`timescale 1ns/1ps
`include "ddr2_pin_map.svh"
module ddr2_ctrl_model
   import ddr2_pin_pkg::*;
(
   input  wire logic               clk_in,
   output logic                    link_clk_out,
   output logic                    cke_out,
   output logic                    cs_n_out,
   output logic [2:0]              cmd_out,
   output logic [`BANK_W-1:0]      bank_out,
   output logic [`ADDR_W-1:0]      addr_out,
   output logic [`DQ_W-1:0]        dq_out,
   output logic                    dqs_out,
   output logic                    mask_out
);
   // ----------------------------------------------
   // Free-running link clock, phase unrelated to clk_in
   // ----------------------------------------------
   initial
   begin
      link_clk_out = 1'b0;
      cke_out = 1'b0;
      cs_n_out = 1'b1;
      cmd_out = cmd_nop;
      bank_out = 2'h0;
      addr_out = 13'h0000;
      dq_out = 8'h00;
      dqs_out = 1'b0;
      mask_out = 1'b0;
      #1.3;
      forever #62.5 link_clk_out = ~link_clk_out;
   end

   // One command around one rising crossing, then deselect
   task cmd(input logic sel_n, input cmd_e code, input logic [1:0] b, input logic [12:0] a);
      @(negedge link_clk_out);
      @(negedge clk_in);
      cs_n_out = sel_n;
      cmd_out = code;
      bank_out = b;
      addr_out = a;
      @(negedge link_clk_out);
      @(negedge clk_in);
      cs_n_out = 1'b1;
      cmd_out = cmd_nop;
   endtask

   // Clock enable changes mid-period, so the next rise registers it
   task set_cke(input logic v);
      @(negedge link_clk_out);
      @(negedge clk_in);
      cke_out = v;
      repeat (2) @(negedge link_clk_out);
   endtask

   // Strobe edge placed mid-beat; data inverted once hold runs out
   task beat(input logic [7:0] d, input logic m);
      repeat (2) @(negedge clk_in);
      dq_out = d;
      mask_out = m;
      repeat (4) @(negedge clk_in);
      dqs_out = ~dqs_out;
      repeat (4) @(negedge clk_in);
      dq_out = ~d;
   endtask
endmodule

// ---- verification/tb.sv ----
// Self-checking bench for the DDR2 command and strobe pins.
// Assumes the controller model drives the pins and the bench the array side.
`timescale 1ns/1ps
`include "ddr2_pin_map.svh"
module tb
   import ddr2_pin_pkg::*;
;
   logic clk_in, rst_n_in, wr_ready_in, rd_valid_in;
   logic link_clk_in, cke_in, cs_n_in, ras_n_in, cas_n_in, we_n_in, dqs_in;
   logic write_data_mask_in, c_dqs, c_mask, dq_oe_out, dqs_out, dqs_oe_out;
   logic dqs_n_out, dqs_n_oe_out, read_data_strobe_out, read_data_strobe_oe_out;
   logic read_data_strobe_n_out, read_data_strobe_n_oe_out, cmd_valid_out;
   logic clock_run_out, strobe_diff_out, read_strobe_en_out, wr_valid_out;
   logic wr_keep_out, wr_overrun_out, rd_ready_out, seen_rs, seen_dn, seen_rn;
   logic [2:0]  cmd_w;
   logic [1:0]  bank_in, cmd_bank_out;
   logic [12:0] addr_in, cmd_addr_out;
   logic [7:0]  dq_in, dq_out, c_dq, wr_data_out, rd_data_in;
   cmd_e        cmd_code_out;
   int          n_fail, n_tests, ncmd, novr, nrd, cyc, k, i, j;

   // ----------------------------------------------
   // Pins, clock and shared-wire resolution
   // ----------------------------------------------
   assign {ras_n_in, cas_n_in, we_n_in} = cmd_w;
   assign dq_in = dq_oe_out ? dq_out : c_dq;
   assign dqs_in = dqs_oe_out ? dqs_out : c_dqs;
   assign write_data_mask_in = read_data_strobe_oe_out ? read_data_strobe_out : c_mask;

   initial
   begin
      clk_in = 1'b0;
      forever #2.5 clk_in = ~clk_in;
   end

   ddr2_ctrl_model i_ddr2_ctrl_model (.clk_in, .link_clk_out(link_clk_in), .cke_out(cke_in),
      .cs_n_out(cs_n_in), .cmd_out(cmd_w), .bank_out(bank_in), .addr_out(addr_in),
      .dq_out(c_dq), .dqs_out(c_dqs), .mask_out(c_mask));

   ddr2_command_strobe_pins i_ddr2_command_strobe_pins (.clk_in, .rst_n_in, .link_clk_in,
      .cke_in, .cs_n_in, .ras_n_in, .cas_n_in, .we_n_in, .bank_in, .addr_in, .dq_in,
      .dq_out, .dq_oe_out, .dqs_in, .dqs_out, .dqs_oe_out, .dqs_n_out, .dqs_n_oe_out,
      .write_data_mask_in, .read_data_strobe_out, .read_data_strobe_oe_out,
      .read_data_strobe_n_out, .read_data_strobe_n_oe_out, .cmd_valid_out,
      .cmd_code_out, .cmd_bank_out, .cmd_addr_out, .clock_run_out, .strobe_diff_out,
      .read_strobe_en_out, .wr_valid_out, .wr_data_out, .wr_keep_out, .wr_ready_in,
      .wr_overrun_out, .rd_valid_in, .rd_data_in, .rd_ready_out);

   // Pulse counters and drive flags; relative counts avoid clearing races
   always @(posedge clk_in)
   begin
      cyc <= cyc + 1;
      if (cmd_valid_out === 1'b1) ncmd <= ncmd + 1;
      if (wr_overrun_out === 1'b1) novr <= novr + 1;
      if (rd_ready_out === 1'b1) nrd <= nrd + 1;
      if (rd_ready_out === 1'b1) rd_data_in <= rd_data_in + 8'h01;
      if (read_data_strobe_oe_out === 1'b1) seen_rs <= 1'b1;
      if (dqs_n_oe_out === 1'b1) seen_dn <= 1'b1;
      if (read_data_strobe_n_oe_out === 1'b1) seen_rn <= 1'b1;
      if (cyc == 8000)
      begin
         n_fail++;
         finish_test();
      end
   end

   // ----------------------------------------------
   // Tasks
   // ----------------------------------------------
   task chk(input string nm, input logic [15:0] e, input logic [15:0] g);
      n_tests++;
      if (g !== e)
      begin
         n_fail++;
         $display("[ERR] %s expected %h seen %h", nm, e, g);
      end
   endtask

   task pop();
      @(negedge clk_in);
      wr_ready_in = 1'b1;
      @(negedge clk_in);
      wr_ready_in = 1'b0;
      @(negedge clk_in);
   endtask

   // Read burst with drive flags cleared; bounded wait for the bus release
   task read_burst();
      @(negedge clk_in);
      {seen_rs, seen_dn, seen_rn} = 3'h0;
      k = nrd;
      i_ddr2_ctrl_model.cmd(1'b0, cmd_read, 2'h0, 13'h0000);
      for (j = 0; j < 300 && dq_oe_out !== 1'b0; j++) @(negedge clk_in);
      chk("read release", 16'h0000, dq_oe_out);
      chk("read beats", 16'h0004, 16'(nrd - k));
   endtask

   task finish_test();
      $display("comparisons %0d mismatches %0d", n_tests, n_fail);
      if (n_fail == 0 && n_tests > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask

   // ----------------------------------------------
   // Test sequence
   // ----------------------------------------------
   initial
   begin
      {n_fail, n_tests, ncmd, novr, nrd, cyc} = '0;
      {rst_n_in, wr_ready_in, rd_valid_in, seen_rs, seen_dn, seen_rn} = 6'h08;
      rd_data_in = 8'h10;
      repeat (3) @(posedge clk_in);
      @(negedge clk_in);
      rst_n_in = 1'b1;
      chk("strobe_diff", 16'h0001, strobe_diff_out);
      chk("read_strobe_en", 16'h0000, read_strobe_en_out);
      chk("dq_oe", 16'h0000, dq_oe_out);
      chk("cmd_code", 16'h0007, cmd_code_out);
      k = ncmd;
      i_ddr2_ctrl_model.cmd(1'b0, cmd_refresh, 2'h0, 13'h0000);
      chk("cmds while stopped", 16'h0000, 16'(ncmd - k));
      $display("test reset and gating done");

      i_ddr2_ctrl_model.set_cke(1'b1);
      chk("clock_run", 16'h0001, clock_run_out);
      for (i = 0; i < 8; i++)
      begin
         k = ncmd;
         i_ddr2_ctrl_model.cmd(1'b0, cmd_e'(i), 2'(i), 13'(i * 3 + 1));
         chk("cmd count", 16'h0001, 16'(ncmd - k));
         chk("cmd bank", 16'(i % 4), cmd_bank_out);
         chk("cmd code", 16'(i), cmd_code_out);
         chk("cmd addr", 16'(i * 3 + 1), cmd_addr_out);
      end
      k = ncmd;
      i_ddr2_ctrl_model.cmd(1'b1, cmd_mode_set, `BANK_EXT_ONE, 13'h0800);
      chk("deselected cmds", 16'h0000, 16'(ncmd - k));
      chk("read_strobe_en", 16'h0000, read_strobe_en_out);
      $display("test command decode done");

      // Two beats fill the buffer, the third is lost
      k = novr;
      i_ddr2_ctrl_model.beat(8'h3C, 1'b0);
      chk("wr_valid", 16'h0001, wr_valid_out);
      chk("wr_data", 16'h003C, wr_data_out);
      chk("wr_keep", 16'h0001, wr_keep_out);
      i_ddr2_ctrl_model.beat(8'hC3, 1'b1);
      i_ddr2_ctrl_model.beat(8'h5A, 1'b0);
      chk("overruns", 16'h0001, 16'(novr - k));
      pop();
      chk("wr_data", 16'h00C3, wr_data_out);
      chk("wr_keep", 16'h0000, wr_keep_out);
      pop();
      chk("wr_valid", 16'h0000, wr_valid_out);
      $display("test write mask done");

      // Read strobe on: mask ignored, shared pin quiet during writes
      i_ddr2_ctrl_model.cmd(1'b0, cmd_mode_set, `BANK_EXT_ONE, 13'h0800);
      chk("strobe_diff", 16'h0001, strobe_diff_out);
      chk("read_strobe_en", 16'h0001, read_strobe_en_out);
      seen_rs = 1'b0;
      i_ddr2_ctrl_model.beat(8'h96, 1'b1);
      chk("wr_keep", 16'h0001, wr_keep_out);
      chk("strobe oe on write", 16'h0000, seen_rs);
      pop();
      read_burst();
      chk("read data", 16'h0017, dq_out);
      chk("dqs postamble", 16'h0000, dqs_out);
      chk("strobe oe on read", 16'h0001, seen_rs);
      chk("dqs_n oe", 16'h0001, seen_dn);
      chk("strobe_n oe", 16'h0001, seen_rn);
      i_ddr2_ctrl_model.cmd(1'b0, cmd_mode_set, `BANK_EXT_ONE, 13'h0C00);
      chk("strobe_diff", 16'h0000, strobe_diff_out);
      read_burst();
      chk("dqs_n oe", 16'h0000, seen_dn);
      chk("strobe_n oe", 16'h0000, seen_rn);
      $display("test read strobes done");

      i_ddr2_ctrl_model.set_cke(1'b0);
      chk("clock_run", 16'h0000, clock_run_out);
      k = ncmd;
      i_ddr2_ctrl_model.cmd(1'b0, cmd_precharge, 2'h0, 13'h0000);
      chk("cmds while stopped", 16'h0000, 16'(ncmd - k));
      $display("test clock stop done");
      finish_test();
   end
endmodule
